// ===== shared/wcba_pkg.sv
// Functional notes
// - each 16-bit register is reached as two byte transfers on the 8-bit bus
// - one shared 8-bit high-byte holding register per timer
// - low-byte write commits holding byte and written byte together in one cycle, for capture only while it defines top
// - counter and capture low-byte reads copy the register's upper half into the holding register
// - counter high-byte location reads and writes the holding register only
// - compare value reads return both halves directly, holding register untouched
// - tick source chosen by three-bit select field in control register b
// - 16-bit up/down counter stepping by one, direction selects up or down
// - clear forces zero; bottom indication the cycle after counter is zero
// - top indication the cycle after counter reaches highest value of its sequence
// - counter mapped onto a high and a low byte location
// - clear, increment or decrement only on timer ticks, per mode
// - select field zero gives no ticks and a stopped counter
// - counter readable and writable whether or not ticks occur
// - cpu counter write wins over a coincident clear or count
// - counting sequence from four-bit waveform mode split over control a and b
// - overflow flag set at a mode-dependent point, usable as interrupt request
// - bottom is 0x0000, maximum is 0xffff
// - top is 0xffff, 0x00ff, 0x01ff, 0x03ff, compare a or capture, per mode
package wcba_pkg;

    // io locations, one byte each
    localparam logic [3:0] ADDR_CTRL_A  = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B  = 4'h1;
    localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
    localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
    localparam logic [3:0] ADDR_CMPC_LO = 4'h8;
    localparam logic [3:0] ADDR_CMPC_HI = 4'h9;
    localparam logic [3:0] ADDR_CAP_LO  = 4'hA;
    localparam logic [3:0] ADDR_CAP_HI  = 4'hB;
    localparam logic [3:0] ADDR_FLAGS   = 4'hC;

    // field positions
    localparam int CTRL_A_WGM_LSB = 0;   // waveform mode bits 1:0
    localparam int CTRL_B_CS_LSB  = 0;   // tick source bits 2:0
    localparam int CTRL_B_WGM_LSB = 3;   // waveform mode bits 3:2
    localparam int FLAGS_OVF_BIT  = 0;

    // reset values
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    // counter landmarks
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT   = 16'h00FF;
    localparam logic [15:0] TOP_9BIT   = 16'h01FF;
    localparam logic [15:0] TOP_10BIT  = 16'h03FF;

    // tick source codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // prescaler terminal masks: tick when the low bits of the divider are all ones
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV64_MASK   = 10'h03F;
    localparam logic [9:0] DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } wcba_io_req_s;

    typedef struct packed {
        logic [3:0] wgm;
        logic [2:0] cs;
    } wcba_ctrl_s;

endpackage : wcba_pkg

// ===== verilog/wcba_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module wcba_tick_gen (
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic [2:0] i_cs,
    input  wire logic       i_ext_pin,
    output var  logic       o_tick
);
    logic [9:0] div_ff;
    logic [9:0] nxt_div;
    logic       ext_meta_ff;
    logic       ext_sync_ff;
    logic       ext_prev_ff;
    logic       tick_ff;
    logic       nxt_tick;

    function automatic logic div_hit(input logic [9:0] cnt, input logic [9:0] mask);
        div_hit = ((cnt & mask) == mask);
    endfunction : div_hit

    always_comb begin
        // free-running divider, so a source change never waits for a wrap
        nxt_div = div_ff + 10'h001;
        unique case (i_cs)
            wcba_pkg::CS_STOP:     nxt_tick = 1'b0;
            wcba_pkg::CS_DIV1:     nxt_tick = 1'b1;
            wcba_pkg::CS_DIV8:     nxt_tick = div_hit(div_ff, wcba_pkg::DIV8_MASK);
            wcba_pkg::CS_DIV64:    nxt_tick = div_hit(div_ff, wcba_pkg::DIV64_MASK);
            wcba_pkg::CS_DIV256:   nxt_tick = div_hit(div_ff, wcba_pkg::DIV256_MASK);
            wcba_pkg::CS_DIV1024:  nxt_tick = div_hit(div_ff, wcba_pkg::DIV1024_MASK);
            wcba_pkg::CS_EXT_FALL: nxt_tick = ext_prev_ff & ~ext_sync_ff;
            wcba_pkg::CS_EXT_RISE: nxt_tick = ~ext_prev_ff & ext_sync_ff;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_ff      <= 10'h000;
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            tick_ff     <= 1'b0;
        end else begin
            div_ff      <= nxt_div;
            ext_meta_ff <= i_ext_pin;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            tick_ff     <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;
endmodule : wcba_tick_gen
`default_nettype wire

// ===== verilog/wcba_timer.sv
`timescale 1ns/10ps
`default_nettype none
module wcba_timer (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    input  wire wcba_pkg::wcba_io_req_s i_io,
    input  wire logic                  i_ext_tick_pin,
    output var  logic [7:0]            o_io_rdata,
    output var  logic [15:0]           o_count_value,
    output var  logic                  o_top,
    output var  logic                  o_bottom,
    output var  logic                  o_overflow_flag
);
    wcba_pkg::wcba_ctrl_s ctrl_ff;
    wcba_pkg::wcba_ctrl_s nxt_ctrl;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic        dir_down_ff;
    logic        nxt_dir_down;
    logic [7:0]  temp_ff;
    logic [7:0]  nxt_temp;
    logic [15:0] cmp_a_ff;
    logic [15:0] cmp_b_ff;
    logic [15:0] cmp_c_ff;
    logic [15:0] cap_ff;
    logic [15:0] nxt_cmp_a;
    logic [15:0] nxt_cmp_b;
    logic [15:0] nxt_cmp_c;
    logic [15:0] nxt_cap;
    logic        ovf_ff;
    logic        nxt_ovf;
    logic        ovf_event;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        top_ff;
    logic        bottom_ff;
    logic        tick;
    logic [15:0] top_value;
    logic        wr_cnt_lo;
    logic        rd_cnt_lo;

    function automatic logic [15:0] top_of(input logic [3:0] wgm,
                                           input logic [15:0] ocra,
                                           input logic [15:0] icr);
        unique case (wgm)
            4'h1, 4'h5:               top_of = wcba_pkg::TOP_8BIT;
            4'h2, 4'h6:               top_of = wcba_pkg::TOP_9BIT;
            4'h3, 4'h7:               top_of = wcba_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF:   top_of = ocra;
            4'h8, 4'hA, 4'hC, 4'hE:   top_of = icr;
            default:                  top_of = wcba_pkg::CNT_MAX;
        endcase
    endfunction : top_of

    function automatic logic dual_slope(input logic [3:0] wgm);
        dual_slope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    endfunction : dual_slope

    function automatic logic fast_pwm(input logic [3:0] wgm);
        fast_pwm = (wgm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
    endfunction : fast_pwm

    function automatic logic icr_is_top(input logic [3:0] wgm);
        icr_is_top = (wgm inside {4'h8, 4'hA, 4'hC, 4'hE});
    endfunction : icr_is_top

    wcba_tick_gen u_tick_gen (
        .i_clock   (i_clock),
        .i_rst_b   (i_rst_b),
        .i_cs      (ctrl_ff.cs),
        .i_ext_pin (i_ext_tick_pin),
        .o_tick    (tick)
    );

    assign top_value = top_of(ctrl_ff.wgm, cmp_a_ff, cap_ff);
    assign wr_cnt_lo = i_io.wr && (i_io.addr == wcba_pkg::ADDR_CNT_LO);
    assign rd_cnt_lo = i_io.rd && (i_io.addr == wcba_pkg::ADDR_CNT_LO);

    // control registers and the holding byte
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_temp  = temp_ff;
        nxt_cmp_a = cmp_a_ff;
        nxt_cmp_b = cmp_b_ff;
        nxt_cmp_c = cmp_c_ff;
        nxt_cap   = cap_ff;
        if (i_io.wr) begin
            unique case (i_io.addr)
                wcba_pkg::ADDR_CTRL_A:
                    nxt_ctrl.wgm[1:0] = i_io.wdata[wcba_pkg::CTRL_A_WGM_LSB +: 2];
                wcba_pkg::ADDR_CTRL_B: begin
                    nxt_ctrl.cs       = i_io.wdata[wcba_pkg::CTRL_B_CS_LSB +: 3];
                    nxt_ctrl.wgm[3:2] = i_io.wdata[wcba_pkg::CTRL_B_WGM_LSB +: 2];
                end
                wcba_pkg::ADDR_CNT_HI, wcba_pkg::ADDR_CMPA_HI, wcba_pkg::ADDR_CMPB_HI,
                wcba_pkg::ADDR_CMPC_HI, wcba_pkg::ADDR_CAP_HI:
                    nxt_temp = i_io.wdata;
                wcba_pkg::ADDR_CMPA_LO: nxt_cmp_a = {temp_ff, i_io.wdata};
                wcba_pkg::ADDR_CMPB_LO: nxt_cmp_b = {temp_ff, i_io.wdata};
                wcba_pkg::ADDR_CMPC_LO: nxt_cmp_c = {temp_ff, i_io.wdata};
                wcba_pkg::ADDR_CAP_LO: begin
                    // capture only accepts writes while it defines top
                    if (icr_is_top(ctrl_ff.wgm)) begin
                        nxt_cap = {temp_ff, i_io.wdata};
                    end
                end
                default: ;
            endcase
        end
        if (rd_cnt_lo) begin
            nxt_temp = count_ff[15:8];
        end else if (i_io.rd && (i_io.addr == wcba_pkg::ADDR_CAP_LO)) begin
            nxt_temp = cap_ff[15:8];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_ff  <= '0;
            temp_ff  <= wcba_pkg::BYTE_RESET;
            cmp_a_ff <= wcba_pkg::CNT_RESET;
            cmp_b_ff <= wcba_pkg::CNT_RESET;
            cmp_c_ff <= wcba_pkg::CNT_RESET;
            cap_ff   <= wcba_pkg::CNT_RESET;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            temp_ff  <= nxt_temp;
            cmp_a_ff <= nxt_cmp_a;
            cmp_b_ff <= nxt_cmp_b;
            cmp_c_ff <= nxt_cmp_c;
            cap_ff   <= nxt_cap;
        end
    end

    // counter unit
    always_comb begin
        nxt_count    = count_ff;
        nxt_dir_down = dir_down_ff;
        ovf_event    = 1'b0;
        if (wr_cnt_lo) begin
            nxt_count = {temp_ff, i_io.wdata};
        end else if (tick) begin
            if (dual_slope(ctrl_ff.wgm)) begin
                if (!dir_down_ff) begin
                    // >= keeps the counter bounded when top is lowered on the fly
                    if (count_ff >= top_value) begin
                        nxt_count    = count_ff - 16'h0001;
                        nxt_dir_down = 1'b1;
                    end else begin
                        nxt_count = count_ff + 16'h0001;
                    end
                end else if (count_ff == wcba_pkg::CNT_BOTTOM) begin
                    nxt_count    = count_ff + 16'h0001;
                    nxt_dir_down = 1'b0;
                    ovf_event    = 1'b1;
                end else begin
                    nxt_count = count_ff - 16'h0001;
                end
            end else begin
                nxt_dir_down = 1'b0;
                if (count_ff >= top_value) begin
                    nxt_count = wcba_pkg::CNT_BOTTOM;
                    ovf_event = fast_pwm(ctrl_ff.wgm) ||
                                (count_ff == wcba_pkg::CNT_MAX);
                end else begin
                    nxt_count = count_ff + 16'h0001;
                end
            end
        end
    end

    // overflow flag: write one clears, a coincident set wins
    always_comb begin
        nxt_ovf = ovf_ff;
        if (i_io.wr && (i_io.addr == wcba_pkg::ADDR_FLAGS) &&
            i_io.wdata[wcba_pkg::FLAGS_OVF_BIT]) begin
            nxt_ovf = 1'b0;
        end
        if (ovf_event) begin
            nxt_ovf = 1'b1;
        end
    end

    // read path: answer one cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_io.rd) begin
            unique case (i_io.addr)
                wcba_pkg::ADDR_CTRL_A:  nxt_rdata = {6'h00, ctrl_ff.wgm[1:0]};
                wcba_pkg::ADDR_CTRL_B:  nxt_rdata = {3'h0, ctrl_ff.wgm[3:2], ctrl_ff.cs};
                wcba_pkg::ADDR_CNT_LO:  nxt_rdata = count_ff[7:0];
                wcba_pkg::ADDR_CNT_HI:  nxt_rdata = temp_ff;
                wcba_pkg::ADDR_CMPA_LO: nxt_rdata = cmp_a_ff[7:0];
                wcba_pkg::ADDR_CMPA_HI: nxt_rdata = cmp_a_ff[15:8];
                wcba_pkg::ADDR_CMPB_LO: nxt_rdata = cmp_b_ff[7:0];
                wcba_pkg::ADDR_CMPB_HI: nxt_rdata = cmp_b_ff[15:8];
                wcba_pkg::ADDR_CMPC_LO: nxt_rdata = cmp_c_ff[7:0];
                wcba_pkg::ADDR_CMPC_HI: nxt_rdata = cmp_c_ff[15:8];
                wcba_pkg::ADDR_CAP_LO:  nxt_rdata = cap_ff[7:0];
                wcba_pkg::ADDR_CAP_HI:  nxt_rdata = temp_ff;
                wcba_pkg::ADDR_FLAGS:   nxt_rdata = {7'h00, ovf_ff};
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_ff    <= wcba_pkg::CNT_RESET;
            dir_down_ff <= 1'b0;
            ovf_ff      <= 1'b0;
            rdata_ff    <= wcba_pkg::BYTE_RESET;
            top_ff      <= 1'b0;
            bottom_ff   <= 1'b0;
        end else begin
            count_ff    <= nxt_count;
            dir_down_ff <= nxt_dir_down;
            ovf_ff      <= nxt_ovf;
            rdata_ff    <= nxt_rdata;
            // indications trail the count by one cycle to keep outputs registered
            top_ff      <= (count_ff == top_value);
            bottom_ff   <= (count_ff == wcba_pkg::CNT_BOTTOM);
        end
    end

    assign o_io_rdata      = rdata_ff;
    assign o_count_value   = count_ff;
    assign o_top           = top_ff;
    assign o_bottom        = bottom_ff;
    assign o_overflow_flag = ovf_ff;

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_low_write_commit: assert property (
        wr_cnt_lo |=> count_ff == {$past(temp_ff), $past(i_io.wdata)})
        else $error("counter low write did not commit both halves");

    a_low_read_latch: assert property (
        rd_cnt_lo |=> temp_ff == $past(count_ff[15:8]))
        else $error("low read did not load holding byte");

    a_high_via_temp: assert property (
        i_io.rd && i_io.addr == wcba_pkg::ADDR_CNT_HI |=> o_io_rdata == $past(temp_ff))
        else $error("counter high read bypassed holding byte");

    a_high_write_only: assert property (
        i_io.wr && i_io.addr == wcba_pkg::ADDR_CNT_HI && !tick
        |=> count_ff == $past(count_ff) && temp_ff == $past(i_io.wdata))
        else $error("counter high write touched the counter");

    a_cmp_read_direct: assert property (
        i_io.rd && !i_io.wr && i_io.addr == wcba_pkg::ADDR_CMPA_HI
        |=> o_io_rdata == $past(cmp_a_ff[15:8]) && $stable(temp_ff))
        else $error("compare read used the holding byte");

    a_stopped_hold: assert property (
        ctrl_ff.cs == wcba_pkg::CS_STOP && $past(ctrl_ff.cs) == wcba_pkg::CS_STOP
        && !wr_cnt_lo |=> $stable(count_ff))
        else $error("counter moved with no source");

    a_tick_only: assert property (
        !tick && !wr_cnt_lo |=> $stable(count_ff))
        else $error("counter moved without a tick");

    a_up_step: assert property (
        tick && !wr_cnt_lo && ctrl_ff.wgm == 4'h0 && count_ff != wcba_pkg::CNT_MAX
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("normal mode did not step by one");

    a_write_wins: assert property (
        wr_cnt_lo && tick |=> count_ff[7:0] == $past(i_io.wdata))
        else $error("count won over cpu write");

    a_bottom_flag: assert property (
        count_ff == wcba_pkg::CNT_BOTTOM |=> o_bottom)
        else $error("bottom indication missing");

    a_top_flag: assert property (
        count_ff == top_value |=> o_top)
        else $error("top indication missing");

    a_ovf_wrap: assert property (
        tick && !wr_cnt_lo && ctrl_ff.wgm == 4'h0 && count_ff == wcba_pkg::CNT_MAX
        |=> o_overflow_flag && count_ff == wcba_pkg::CNT_BOTTOM)
        else $error("overflow not set at wrap");

    a_clear_at_top: assert property (
        tick && !wr_cnt_lo && !dual_slope(ctrl_ff.wgm) && count_ff >= top_value
        |=> count_ff == wcba_pkg::CNT_BOTTOM)
        else $error("single slope count did not clear at top");

    a_ovf_set_wins: assert property (
        ovf_event |=> o_overflow_flag)
        else $error("overflow set lost to a clear");

    c_full_write: cover property (
        i_io.wr && i_io.addr == wcba_pkg::ADDR_CNT_HI ##[1:4] wr_cnt_lo);
    c_full_read: cover property (
        rd_cnt_lo ##[1:4] i_io.rd && i_io.addr == wcba_pkg::ADDR_CNT_HI);
    c_dual_turn: cover property (dir_down_ff ##1 !dir_down_ff);
    c_overflow: cover property (!o_overflow_flag ##1 o_overflow_flag);
    c_write_on_tick: cover property (wr_cnt_lo && tick);

endmodule : wcba_timer
`default_nettype wire

// ===== test/wcba_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module wcba_cpu_model (
    input  wire logic                   i_clock,
    input  wire logic [7:0]             i_rdata,
    output var  wcba_pkg::wcba_io_req_s o_io
);
    initial o_io = '0;
    // a request is set after an edge and held until the edge that takes it
    task automatic xfer(input logic rd, input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
        o_io <= '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge i_clock);
    endtask : xfer
    // released lines flip so a stale copy can never pass for data
    task automatic idle();
        o_io <= '{rd: 1'b0, wr: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
        @(posedge i_clock);
    endtask : idle
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        xfer(1'b0, 1'b1, a, d);
        idle();
    endtask : wr8
    task automatic rd8(input logic [3:0] a, output logic [7:0] v);
        xfer(1'b1, 1'b0, a, ~o_io.wdata);
        idle();
        v = i_rdata;
    endtask : rd8
    // two-byte sequences run whole, nothing else interleaves
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        xfer(1'b0, 1'b1, a + 4'h1, v[15:8]);
        xfer(1'b0, 1'b1, a, v[7:0]);
        idle();
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        xfer(1'b1, 1'b0, a, ~o_io.wdata);
        xfer(1'b1, 1'b0, a + 4'h1, ~o_io.wdata);
        v[7:0] = i_rdata;
        idle();
        v[15:8] = i_rdata;
    endtask : rd16
endmodule : wcba_cpu_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                   i_clock = 1'b0;
    logic                   i_rst_b = 1'b0;
    logic                   pin     = 1'b0;
    wcba_pkg::wcba_io_req_s io;
    logic [7:0]             rdata, b;
    logic [15:0]            cnt, v, c0, mx;
    logic                   top, bot, ovf, top_seen;
    int                     failures = 0;
    int                     samples_checked = 0;
    int                     cycles = 0;
    logic [3:0]  md_t [5] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h1};
    logic [15:0] st_t [5] = '{16'hFFFE, 16'h00FD, 16'h01FD, 16'h03FD, 16'h00FE};
    logic [15:0] ex_t [5] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h00FD};
    logic        ov_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    always #2 i_clock = ~i_clock;
    wcba_timer wcba_timer_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_io(io),
        .i_ext_tick_pin(pin), .o_io_rdata(rdata), .o_count_value(cnt),
        .o_top(top), .o_bottom(bot), .o_overflow_flag(ovf));
    wcba_cpu_model wcba_cpu_model_inst (.i_clock(i_clock), .i_rdata(rdata), .o_io(io));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic set_mode(input logic [3:0] md, input logic [2:0] cs);
        wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_CTRL_A, {6'h00, md[1:0]});
        wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_CTRL_B, {3'h0, md[3:2], cs});
    endtask : set_mode
    // a hang ends in the same report as a normal run
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clock);
        check("bottom", {15'h0000, bot}, 16'h0001);
        check("count", cnt, 16'h0000);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CNT_LO, 16'h01FF);
        check("count", cnt, 16'h01FF);
        wcba_cpu_model_inst.rd16(wcba_pkg::ADDR_CNT_LO, v);
        check("count read", v, 16'h01FF);
        check("bottom", {15'h0000, bot}, 16'h0000);
        wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_CNT_HI, 8'hAB);
        wcba_cpu_model_inst.rd8(wcba_pkg::ADDR_CNT_HI, b);
        check("holding", {8'h00, b}, 16'h00AB);
        check("count", cnt, 16'h01FF);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CMPA_LO, 16'h1234);
        wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_CNT_HI, 8'h77);
        wcba_cpu_model_inst.rd16(wcba_pkg::ADDR_CMPA_LO, v);
        check("compare a", v, 16'h1234);
        wcba_cpu_model_inst.rd8(wcba_pkg::ADDR_CNT_HI, b);
        check("holding", {8'h00, b}, 16'h0077);
        wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_CMPA_HI, 8'h05);
        for (int i = 0; i < 3; i++) begin
            wcba_cpu_model_inst.wr8(4'(wcba_pkg::ADDR_CMPA_LO + 2 * i), 8'(16 * i + 16));
        end
        for (int i = 0; i < 3; i++) begin
            wcba_cpu_model_inst.rd16(4'(wcba_pkg::ADDR_CMPA_LO + 2 * i), v);
            check("compare", v, 16'(16'h0510 + 16 * i));
        end
        wcba_cpu_model_inst.rd8(4'hD, b);
        check("unmapped", {8'h00, b}, 16'h0000);
        // capture takes writes only while it sets top; low read loads the holding byte
        set_mode(4'hC, wcba_pkg::CS_STOP);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CAP_LO, 16'h0345);
        wcba_cpu_model_inst.rd16(wcba_pkg::ADDR_CAP_LO, v);
        check("capture", v, 16'h0345);
        set_mode(4'h0, wcba_pkg::CS_STOP);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CAP_LO, 16'h0999);
        wcba_cpu_model_inst.rd16(wcba_pkg::ADDR_CAP_LO, v);
        check("capture", v, 16'h0345);
        set_mode(4'h0, wcba_pkg::CS_DIV1);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CNT_LO, 16'h1000);
        check("count", cnt, 16'h1000);
        @(posedge i_clock);
        check("count", cnt, 16'h1001);
        wcba_cpu_model_inst.rd16(wcba_pkg::ADDR_CNT_LO, v);
        check("count read", v, 16'h1002);
        for (int i = 0; i < 5; i++) begin
            set_mode(md_t[i], wcba_pkg::CS_DIV1);
            wcba_cpu_model_inst.wr8(wcba_pkg::ADDR_FLAGS, 8'h01);
            wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CNT_LO, st_t[i]);
            repeat (3) @(posedge i_clock);
            check("count", cnt, ex_t[i]);
            check("overflow", {15'h0000, ovf}, {15'h0000, ov_t[i]});
        end
        // top from compare a: the count never passes it and top is flagged
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CMPA_LO, 16'h0008);
        set_mode(4'h4, wcba_pkg::CS_DIV1);
        wcba_cpu_model_inst.wr16(wcba_pkg::ADDR_CNT_LO, 16'h0000);
        mx = 16'h0000;
        top_seen = 1'b0;
        repeat (24) begin
            @(posedge i_clock);
            if (cnt > mx) mx = cnt;
            if (top === 1'b1) top_seen = 1'b1;
        end
        check("max count", mx, 16'h0008);
        check("top seen", {15'h0000, top_seen}, 16'h0001);
        set_mode(4'h0, wcba_pkg::CS_DIV8);
        @(posedge i_clock);
        c0 = cnt;
        repeat (64) @(posedge i_clock);
        check("divided ticks", cnt - c0, 16'h0008);
        for (int k = 0; k < 2; k++) begin
            set_mode(4'h0, (k == 1) ? wcba_pkg::CS_EXT_FALL : wcba_pkg::CS_EXT_RISE);
            @(posedge i_clock);
            c0 = cnt;
            repeat (3) begin
                pin <= 1'b1;
                repeat (6) @(posedge i_clock);
                pin <= 1'b0;
                repeat (6) @(posedge i_clock);
            end
            check("pin ticks", cnt - c0, 16'h0003);
        end
        set_mode(4'h0, wcba_pkg::CS_STOP);
        @(posedge i_clock);
        c0 = cnt;
        repeat (20) @(posedge i_clock);
        check("stopped", cnt, c0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
